// >>> fprb_top.v
// Purpose: reset initialisation and host port-width configuration
// Assumes: straps static, clock free running, host holds reset long enough
// Notes: acknowledges are active low; both high means wait state
//        pins pulled high for one cycle after the strobe, then released
//        straps are read once per reset; later changes are ignored
// Overview of operation
// - During reset, data registers hold quiet NaN; control, status, address cleared.
// - Both straps high selects 32-bit port.
// - Width strap high, address strap low selects 16-bit port.
// - In 16-bit mode low-order acknowledge never asserted.
// - Width strap low selects 8-bit port regardless of address strap.
// - In 8-bit mode high-order acknowledge never asserted.
// - Without bus sizing, high-order acknowledge serves as host transfer ack.
// - Both acknowledges negated means cycle incomplete, host waits.
// - 32-bit: both acks when address bit 4 set, else high-order only.
`timescale 1ns/100ps
`default_nettype none
`include "fprb_map.vh"
module fprb_top (
   input wire clk_in,
   input wire rstn_in,
   input wire width_strap_in,
   input wire addr_strap_in,
   input wire cs_n_in,
   input wire as_n_in,
   input wire addr4_in,
   input wire ready_in,
   input wire [2:0] fp_sel_in,
   output reg ack_high_order_n_out,
   output reg ack_low_order_n_out,
   output reg ack_oe_out,
   output reg [1:0] width_out,
   output reg init_done_out,
   output reg [`FPRB_FP_REG_W-1:0] fp_data_out,
   output reg [31:0] ctrl_out,
   output reg [31:0] stat_out,
   output reg [31:0] iaddr_out,
   output reg sense_out
);
   // Bus cycle states
   localparam ST_IDLE = 2'b00;
   localparam ST_ACK = 2'b01;
   localparam ST_NEG = 2'b10;

   // Data registers, loaded only by reset here
   reg [`FPRB_FP_REG_W-1:0] fp_reg [0:`FPRB_NUM_FP_REGS-1];

   // Strap capture
   reg latched_reg;
   reg latched_next;
   reg [1:0] width_next;
   reg init_done_next;

   // Cycle sequencing
   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg addr4_reg;
   wire addr4_pick;
   wire req_seen;
   wire strobe_gone;

   // Acknowledge pins
   wire ack_hi;
   wire ack_lo;
   reg ack_high_order_n_next;
   reg ack_low_order_n_next;
   reg ack_oe_next;

   // Width strap low forces the byte port
   function [1:0] width_decode;
      input width_strap;
      input addr_strap;
      begin
         if (!width_strap)
            width_decode = `FPRB_WIDTH_8;
         else if (addr_strap)
            width_decode = `FPRB_WIDTH_32;
         else
            width_decode = `FPRB_WIDTH_16;
      end
   endfunction

   // One reset-loaded register per slot
   genvar gi;
   generate
      for (gi = 0; gi < `FPRB_NUM_FP_REGS; gi = gi + 1) begin : g_fp
         always @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in)
               fp_reg[gi] <= `FPRB_QNAN;
            else
               fp_reg[gi] <= fp_reg[gi];
         end
      end
   endgenerate

   // Architectural registers, cleared while reset is low; data output loads quiet NaN
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_out <= `FPRB_CTRL_RST;
         stat_out <= `FPRB_STAT_RST;
         iaddr_out <= `FPRB_IADDR_RST;
         fp_data_out <= `FPRB_QNAN;
      end else begin
         ctrl_out <= ctrl_out;
         stat_out <= stat_out;
         iaddr_out <= iaddr_out;
         fp_data_out <= fp_reg[fp_sel_in];
      end
   end

   // Sense pin is die ground; it never leaves low
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in)
         sense_out <= 1'b0;
      else
         sense_out <= 1'b0;
   end

   // Straps caught on first edge after release, then frozen
   always @* begin
      latched_next = 1'b1;
      width_next = width_out;
      init_done_next = latched_reg;
      if (!latched_reg)
         width_next = width_decode(width_strap_in, addr_strap_in);
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         latched_reg <= 1'b0;
         width_out <= `FPRB_WIDTH_8;
         init_done_out <= 1'b0;
      end else begin
         latched_reg <= latched_next;
         width_out <= width_next;
         init_done_out <= init_done_next;
      end
   end

   // Request taken only once straps are latched and the datapath is ready
   assign req_seen = init_done_out && !cs_n_in && !as_n_in && ready_in;
   assign strobe_gone = as_n_in || cs_n_in;

   // Address bit follows the bus while idle, frozen while the ack stands
   assign addr4_pick = (state_reg == ST_IDLE) ? addr4_in : addr4_reg;

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in)
         addr4_reg <= 1'b0;
      else
         addr4_reg <= addr4_pick;
   end

   fprb_ack_dec u_dec (
      .width_in(width_out),
      .addr4_in(addr4_pick),
      .done_in(init_done_out),
      .ack_high_order_out(ack_hi),
      .ack_low_order_out(ack_lo)
   );

   // Cycle sequencing: ack when ready, drive high after strobe, then release
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (req_seen)
               state_next = ST_ACK;
         end
         ST_ACK: begin
            if (strobe_gone)
               state_next = ST_NEG;
         end
         ST_NEG: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   // Pin values for the state being entered
   // Lines are driven high one cycle before release to speed the rise
   always @* begin
      ack_high_order_n_next = 1'b1;
      ack_low_order_n_next = 1'b1;
      ack_oe_next = 1'b0;
      case (state_next)
         ST_ACK: begin
            ack_high_order_n_next = ~ack_hi;
            ack_low_order_n_next = ~ack_lo;
            ack_oe_next = 1'b1;
         end
         ST_NEG: begin
            ack_oe_next = 1'b1;
         end
         default: begin
            ack_oe_next = 1'b0;
         end
      endcase
   end

   // Registered pins; reset leaves the lines released
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_reg <= ST_IDLE;
         ack_high_order_n_out <= 1'b1;
         ack_low_order_n_out <= 1'b1;
         ack_oe_out <= 1'b0;
      end else begin
         state_reg <= state_next;
         ack_high_order_n_out <= ack_high_order_n_next;
         ack_low_order_n_out <= ack_low_order_n_next;
         ack_oe_out <= ack_oe_next;
      end
   end
endmodule
`default_nettype wire

// >>> fprb_map.vh
// Purpose: constants for the reset and port-width block
// Assumes: 200 MHz clock
// Notes: width codes, register reset values and reset cycle counts
`ifndef FPRB_MAP_VH
`define FPRB_MAP_VH
`define FPRB_WIDTH_32 2'h2
`define FPRB_WIDTH_16 2'h1
`define FPRB_WIDTH_8 2'h0
`define FPRB_NUM_FP_REGS 8
`define FPRB_FP_REG_W 80
`define FPRB_QNAN 80'h7FFFFFFFFFFFFFFFFFFF
`define FPRB_CTRL_RST 32'h00000000
`define FPRB_STAT_RST 32'h00000000
`define FPRB_IADDR_RST 32'h00000000
`define FPRB_RST_MIN_CYC 4
`define FPRB_RST_LATER_CYC 3
`endif

// >>> fprb_ack_dec.v
// Purpose: acknowledge pattern decode for the selected port width
// Assumes: width code is static
// Notes: outputs active high, one bit per acknowledge line
`timescale 1ns/100ps
`default_nettype none
`include "fprb_map.vh"
module fprb_ack_dec (
   input wire [1:0] width_in,
   input wire addr4_in,
   input wire done_in,
   output reg ack_high_order_out,
   output reg ack_low_order_out
);
   always @* begin
      ack_high_order_out = 1'b0;
      ack_low_order_out = 1'b0;
      if (done_in) begin
         case (width_in)
            `FPRB_WIDTH_32: begin
               ack_high_order_out = 1'b1;
               ack_low_order_out = addr4_in;
            end
            `FPRB_WIDTH_16: begin
               ack_high_order_out = 1'b1;
            end
            default: begin
               ack_low_order_out = 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> fprb_chk_assertions.sv
// Purpose: port checks for the width block
// Assumes: straps static
// Notes: acks active low
`timescale 1ns/100ps
`default_nettype none
module fprb_chk (
   input wire clk_in,
   input wire rstn_in,
   input wire cs_n_in,
   input wire as_n_in,
   input wire addr4_in,
   input wire ready_in,
   input wire ack_high_order_n_out,
   input wire ack_low_order_n_out,
   input wire ack_oe_out,
   input wire [1:0] width_out,
   input wire init_done_out,
   input wire sense_out
);
   wire h = ack_high_order_n_out;
   wire l = ack_low_order_n_out;
   wire [1:0] w = width_out;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_take;
      init_done_out && !cs_n_in && !as_n_in && ready_in && h && l && !ack_oe_out;
   endsequence
   sequence s_drop;
      h && l && ack_oe_out ##1 !ack_oe_out;
   endsequence
   a_no_low16: assert property (width_out == 2'h1 |-> l) else $error("low ack");
   a_no_high8: assert property (width_out == 2'h0 |-> h) else $error("high ack");
   a_wait_state: assert property (!ready_in && h && l |=> h && l) else $error("wait");
   a_take_both: assert property (s_take and w == 2'h2 && addr4_in |=> !h && !l)
      else $error("32 both");
   a_take_upper: assert property (s_take and w == 2'h2 && !addr4_in |=> !h && l)
      else $error("32 upper");
   a_take_half: assert property (s_take and w == 2'h1 |=> !h && l) else $error("16");
   a_take_byte: assert property (s_take and w == 2'h0 |=> h && !l) else $error("8");
   a_ack_release: assert property ((!h || !l) && (as_n_in || cs_n_in) |=> s_drop)
      else $error("release");
   a_width_hold: assert property (init_done_out && $past(init_done_out)
      |-> $stable(width_out)) else $error("width moved");
   a_sense_low: assert property (!sense_out) else $error("sense");
endmodule
bind fprb_top fprb_chk u_chk (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
   .as_n_in(as_n_in), .addr4_in(addr4_in), .ready_in(ready_in),
   .ack_high_order_n_out(ack_high_order_n_out), .ack_low_order_n_out(ack_low_order_n_out),
   .ack_oe_out(ack_oe_out), .width_out(width_out), .init_done_out(init_done_out),
   .sense_out(sense_out));
`default_nettype wire

// >>> fprb_host.sv
// Purpose: host side of the ack and sense pins
// Assumes: pull-ups on acks and sense
// Notes: released acks read high
`timescale 1ns/100ps
`default_nettype none
module fprb_host (
   input wire ack_high_order_n_in,
   input wire ack_oe_in,
   input wire sense_in,
   input wire dev_hit_in,
   input wire data_space_in,
   output wire host_transfer_ack_n_out,
   output wire fitted_out,
   output wire cs_n_out
);
   // Device decoded only inside user or supervisor data space
   assign cs_n_out = ~(dev_hit_in & data_space_in);
   assign host_transfer_ack_n_out = ack_oe_in ? ack_high_order_n_in : 1'b1;
   assign fitted_out = (sense_in === 1'b0);
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: bench for the width block
// Assumes: straps set under reset
// Notes: inputs move on falling edges
`timescale 1ns/100ps
`default_nettype none
`include "fprb_map.vh"
module testbench;
   reg clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg ws = 1'b1;
   reg as = 1'b1;
   reg hit = 1'b0;
   reg dspace = 1'b0;
   reg as_n = 1'b1;
   reg a4 = 1'b0;
   reg rdy = 1'b0;
   reg [2:0] sel = 3'h0;
   wire hn, ln, oe, done, sense, tack_n, fitted, cs_n;
   wire [1:0] wd;
   wire [79:0] fp;
   wire [31:0] c, s, ia;
   integer error_cnt = 0;
   integer num_checks = 0;
   integer i;
   always #2.5 clk_in = ~clk_in;
   fprb_top u_fprb_top (.clk_in(clk_in), .rstn_in(rstn_in), .width_strap_in(ws),
      .addr_strap_in(as), .cs_n_in(cs_n), .as_n_in(as_n), .addr4_in(a4), .ready_in(rdy),
      .fp_sel_in(sel), .ack_high_order_n_out(hn), .ack_low_order_n_out(ln), .ack_oe_out(oe),
      .width_out(wd), .init_done_out(done), .fp_data_out(fp), .ctrl_out(c), .stat_out(s),
      .iaddr_out(ia), .sense_out(sense));
   fprb_host u_fprb_host (.ack_high_order_n_in(hn), .ack_oe_in(oe), .sense_in(sense),
      .dev_hit_in(hit), .data_space_in(dspace), .host_transfer_ack_n_out(tack_n),
      .fitted_out(fitted), .cs_n_out(cs_n));
   task check(input [79:0] seen, input [79:0] exp, input [63:0] name);
   begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
         error_cnt = error_cnt + 1;
         $display("ERROR %0s exp %h seen %h", name, exp, seen);
      end
   end
   endtask
   task final_report;
   begin
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task t_reset(input w, input a, input [1:0] ew);
   begin
      rstn_in = 1'b0;
      ws = w;
      as = a;
      repeat (12) @(negedge clk_in);
      check(c | s | ia, 80'h0, "zero");
      rstn_in = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
         sel = i[2:0];
         @(negedge clk_in);
         check(fp, `FPRB_QNAN, "qnan");
         check(done, i != 0, "done");
      end
      check(wd, ew, "width");
      ws = ~w; // Straps must be ignored now
      as = ~a;
   end
   endtask
   task t_access(input a, input eh, input el);
      integer n;
   begin
      a4 = a;
      hit = 1'b1;
      as_n = 1'b0;
      rdy = 1'b1;
      repeat (2) @(negedge clk_in);
      check({oe, hn, ln}, 3'h3, "nodata");
      dspace = 1'b1;
      rdy = 1'b0;
      repeat (3) @(negedge clk_in);
      check({oe, hn, ln}, 3'h3, "wait");
      rdy = 1'b1;
      n = 0;
      while (oe !== 1'b1 && n < 8) begin
         @(negedge clk_in);
         n = n + 1;
      end
      if (oe !== 1'b1) begin
         error_cnt = error_cnt + 1;
         final_report;
      end
      check({hn, ln, tack_n}, {eh, el, eh}, "acks");
      as_n = 1'b1;
      hit = 1'b0;
      dspace = 1'b0;
      rdy = 1'b0;
      @(negedge clk_in);
      check({oe, hn, ln}, 3'h7, "drive");
      @(negedge clk_in);
      check(oe, 1'b0, "hiz");
      $display("access done a4 %0d width %0d", a, wd);
   end
   endtask
   initial begin
      // Power-up hold kept short to bound run time
      t_reset(1'b1, 1'b1, `FPRB_WIDTH_32);
      check(fitted, 1'b1, "sense");
      t_access(1'b1, 1'b0, 1'b0);
      t_access(1'b0, 1'b0, 1'b1);
      t_reset(1'b1, 1'b0, `FPRB_WIDTH_16);
      t_access(1'b1, 1'b0, 1'b1);
      t_reset(1'b0, 1'b1, `FPRB_WIDTH_8);
      t_access(1'b0, 1'b1, 1'b0);
      t_reset(1'b0, 1'b0, `FPRB_WIDTH_8);
      t_access(1'b1, 1'b1, 1'b0);
      final_report;
   end
endmodule
`default_nettype wire
